// >>> flm_regs.svh
// flm_regs.svh: offsets, field positions, reset values and timing counts of the loop poller
// assumes a 40 MHz clock and classic wishbone with 32-bit data
//
// Functional notes
// - four master channels, each with its own configuration, running independently.
// - each channel talks to instruments at 1200 baud using fsk.
// - a channel serves a multi-drop network of at most fifteen slaves.
// - mode N runs only the command list; M and P add auto-polling.
// - point-to-point mode auto-polls only short address zero into the database.
// - multi-drop mode auto-polls short addresses one through fifteen.
// - a configurable limit bounds the highest address visited by multi-drop polling.
// - each channel holds a user command list of up to 99 entries.
// - write payload comes from the database or the entry's constant, per entry.
// - long addressing first reads the long address by short address, then sends.
// - a config bit enables second-master pauses; cleared gives full throughput.
// - response payloads go into the shared database, exchanged with the host.
// - integer, 32-bit float and packed-character fields; characters unpacked to integers.
// - universal and common-practice commands steer float results to the float area; device-specific go to integers.
// - type zero entries are never sent; they place matching burst frames.
// - build command from database, transmit, receive response, store into database.
// - the device also reports its own module status to the host.
`ifndef FLM_REGS_SVH
`define FLM_REGS_SVH

`define FLM_NCH       4
`define FLM_CLK_NS    25
`define FLM_BIT_NS    833333
`define FLM_BAUD_CYC  (`FLM_BIT_NS / `FLM_CLK_NS)
`define FLM_GAP_MS    20
`define FLM_GAP_CYC   ((`FLM_GAP_MS * 1000000 + `FLM_CLK_NS - 1) / `FLM_CLK_NS)

`define FLM_OFS_STS   12'h000
`define FLM_OFS_MSK   12'h004
`define FLM_OFS_MOD   12'h008
`define FLM_OFS_CFG0  12'h010
`define FLM_RST_CFG   32'h0000_0000

`define FLM_CFG_MODE  1:0
`define FLM_CFG_SEC   2
`define FLM_CFG_MAX   7:4
`define FLM_CFG_CNT   14:8
`define FLM_CFG_FB    23:16
`define FLM_CFG_AB    31:24

`define FLM_E_TYP     1:0
`define FLM_E_LNG     2
`define FLM_E_CSEL    3
`define FLM_E_SADR    7:4
`define FLM_E_CNUM    15:8
`define FLM_E_DBA     23:16
`define FLM_E_CVAL    31:24

`define FLM_MAX_CMDS  7'h63
`define FLM_MAX_DROP  4'hf
`define FLM_AUTO_CMD  8'h03
`define FLM_ID_CMD    8'h00
`define FLM_DEV_SPEC  8'h80

`endif

// >>> flm_pkg.sv
// flm_pkg.sv: types shared by the loop poller
// assumes flm_regs.svh for all numeric constants
package flm_pkg;
  typedef enum logic [3:0] {S_IDLE, S_PICK, S_LQRY, S_SEND, S_ST0, S_ST1, S_GAP, S_BSCN} flm_st_t;
  typedef enum logic [1:0] {MODE_N, MODE_M, MODE_P} flm_mode_t;
  typedef enum logic [1:0] {RT_INT, RT_FLT, RT_PCK} flm_rt_t;
  typedef enum logic [1:0] {TYP_BURST, TYP_RD, TYP_WR} flm_typ_t;
endpackage

// >>> flm_poller.sv
// flm_poller.sv: four-channel loop master with command lists, auto-poll and burst capture
// assumes a frame engine per channel that serialises requests and reports responses
`timescale 1ns/1ps
`include "flm_regs.svh"
`default_nettype none
module flm_poller #(
  parameter int BAUD_CYC = `FLM_BAUD_CYC,
  parameter int GAP_CYC  = `FLM_GAP_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [11:0]  wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic      [3:0]   lk_req_o,
  output logic      [31:0]  lk_cmd_o,
  output logic      [63:0]  lk_addr_o,
  output logic      [3:0]   lk_long_o,
  output logic      [63:0]  lk_wdata_o,
  input  wire logic [3:0]   lk_done_i,
  input  wire logic [7:0]   lk_rtype_i,
  input  wire logic [127:0] lk_rdata_i,
  input  wire logic [3:0]   lk_burst_i,
  input  wire logic [31:0]  lk_bcmd_i,
  output logic              baud_tick_o,
  output logic              irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [31:0] cl [0:511];
  logic [15:0] db [0:255];
  logic [31:0] cfg [4];
  logic [7:0]  sts;
  logic [7:0]  msk;
  logic [31:0] rv;
  logic [15:0] bcnt;
  logic [3:0]  wreq;
  logic [3:0]  gnt;
  logic [3:0]  busy;
  logic [3:0]  bpd;
  logic [3:0]  evd;
  logic [3:0]  evb;
  logic [7:0]  waddr [4];
  logic [15:0] wval [4];
  logic        acc;
  logic        wr;
  logic        dbw;
  logic [31:0] dbm;

  function automatic logic [31:0] bmask(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] asc(input logic [5:0] c);
    return {1'b0, ~c[5], c};
  endfunction

  // single-cycle classic slave: write lands on the edge that the master samples ack
  assign acc = wb_cyc_i & wb_stb_i;
  assign wr  = acc & wb_we_i & wb_ack_o;
  assign dbw = wr & (wb_adr_i[11:10] == 2'b01);
  assign dbm = bmask({16'h0000, db[wb_adr_i[9:2]]}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc & ~wb_ack_o;
    end
  end

  always_comb begin
    rv = 32'h0000_0000;
    if (wb_adr_i[11]) begin
      rv = cl[wb_adr_i[10:2]];
    end else if (wb_adr_i[10]) begin
      rv = {16'h0000, db[wb_adr_i[9:2]]};
    end else begin
      case (wb_adr_i)
        `FLM_OFS_STS: rv = {24'h000000, sts};
        `FLM_OFS_MSK: rv = {24'h000000, msk};
        `FLM_OFS_MOD: rv = {24'h000000, bpd, busy};
        default: begin
          if (wb_adr_i[11:4] == `FLM_OFS_CFG0 >> 4) begin
            rv = cfg[wb_adr_i[3:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc & ~wb_ack_o) begin
      wb_dat_o <= rv;
    end
  end

  // configuration and interrupt registers; a new event beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts <= 8'h00;
      msk <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        cfg[i] <= `FLM_RST_CFG;
      end
    end else begin
      sts <= (sts & ~((wr && wb_adr_i == `FLM_OFS_STS && wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00)) | {evb, evd};
      if (wr && wb_adr_i == `FLM_OFS_MSK && wb_sel_i[0]) begin
        msk <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i[11:4] == `FLM_OFS_CFG0 >> 4) begin
        cfg[wb_adr_i[3:2]] <= bmask(cfg[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
      end
    end
  end

  assign irq_o = |(sts & msk);

  always_ff @(posedge clk_i) begin
    if (wr && wb_adr_i[11]) begin
      cl[wb_adr_i[10:2]] <= bmask(cl[wb_adr_i[10:2]], wb_dat_i, wb_sel_i);
    end
  end

  // one database write port: the host wins, then the lowest channel waiting
  always_comb begin
    logic blk;
    blk = dbw;
    for (int i = 0; i < 4; i++) begin
      gnt[i] = wreq[i] & ~blk;
      blk = blk | wreq[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (dbw) begin
      db[wb_adr_i[9:2]] <= dbm[15:0];
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (gnt[i]) begin
          db[waddr[i]] <= wval[i];
        end
      end
    end
  end

  // bit-rate strobe for the fsk modems
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else begin
      baud_tick_o <= (bcnt == 16'(BAUD_CYC - 1));
      bcnt <= (bcnt == 16'(BAUD_CYC - 1)) ? 16'h0000 : bcnt + 16'h0001;
    end
  end

  for (genvar g = 0; g < `FLM_NCH; g++) begin : g_ch
    flm_pkg::flm_st_t   st;
    flm_pkg::flm_mode_t md;
    logic [31:0] e;
    logic [31:0] ent;
    logic [31:0] rd;
    logic [31:0] bd;
    logic [31:0] rdw;
    logic [15:0] lrd;
    logic [15:0] oa;
    logic [15:0] wd;
    logic [15:0] w0v;
    logic [15:0] w1v;
    logic [7:0]  oc;
    logic [7:0]  bc;
    logic [7:0]  fa;
    logic [7:0]  w0a;
    logic [7:0]  w1a;
    logic [6:0]  idx;
    logic [6:0]  si;
    logic [6:0]  cnt;
    logic [3:0]  pa;
    logic [3:0]  lim;
    logic [1:0]  rt;
    logic [1:0]  bt;
    logic [19:0] gc;
    logic        turn;
    logic        cau;
    logic        ol;
    logic        bp;
    logic        isb;
    logic        aon;
    logic        uon;
    logic        two;
    logic        dn;
    logic        sec;
    logic        hit;
    logic        fin;

    assign md  = flm_pkg::flm_mode_t'(cfg[g][`FLM_CFG_MODE]);
    assign sec = cfg[g][`FLM_CFG_SEC];
    assign cnt = (cfg[g][`FLM_CFG_CNT] > `FLM_MAX_CMDS) ? `FLM_MAX_CMDS : cfg[g][`FLM_CFG_CNT];
    assign lim = (cfg[g][`FLM_CFG_MAX] == 4'h0) ? `FLM_MAX_DROP : cfg[g][`FLM_CFG_MAX];
    assign aon = (md == flm_pkg::MODE_M) || (md == flm_pkg::MODE_P);
    assign uon = (cnt != 7'h00);
    assign ent = cl[{2'(g), (st == flm_pkg::S_BSCN) ? si : idx}];
    assign dn  = lk_done_i[g];
    assign rdw = lk_rdata_i[g*32 +: 32];
    assign lrd = rdw[15:0];
    assign hit = (ent[`FLM_E_TYP] == flm_pkg::TYP_BURST) && (ent[`FLM_E_CNUM] == bc);

    // result placement, float area only for universal and common-practice numbers
    always_comb begin
      fa  = (e[`FLM_E_CNUM] < `FLM_DEV_SPEC) ? cfg[g][`FLM_CFG_FB] : e[`FLM_E_DBA];
      w0a = e[`FLM_E_DBA];
      w1a = e[`FLM_E_DBA] + 8'h01;
      w0v = rd[15:0];
      w1v = rd[15:0];
      two = 1'b0;
      case (flm_pkg::flm_rt_t'(rt))
        flm_pkg::RT_FLT: begin
          w0a = fa;
          w1a = fa + 8'h01;
          w0v = rd[31:16];
          two = 1'b1;
        end
        flm_pkg::RT_PCK: begin
          w0v = {asc(rd[23:18]), asc(rd[17:12])};
          w1v = {asc(rd[11:6]), asc(rd[5:0])};
          two = 1'b1;
        end
        default: begin
          two = 1'b0;
        end
      endcase
    end

    assign wreq[g]  = (st == flm_pkg::S_ST0) || (st == flm_pkg::S_ST1);
    assign waddr[g] = (st == flm_pkg::S_ST0) ? w0a : w1a;
    assign wval[g]  = (st == flm_pkg::S_ST0) ? w0v : w1v;
    assign busy[g]  = (st != flm_pkg::S_IDLE);
    assign bpd[g]   = bp;
    assign fin = (st == flm_pkg::S_SEND && dn && e[`FLM_E_TYP] == flm_pkg::TYP_WR)
               || (st == flm_pkg::S_ST0 && gnt[g] && !two) || (st == flm_pkg::S_ST1 && gnt[g]);
    assign evd[g] = fin & ~isb;
    assign evb[g] = fin & isb;

    assign lk_req_o[g]         = (st == flm_pkg::S_LQRY) || (st == flm_pkg::S_SEND);
    assign lk_cmd_o[g*8 +: 8]   = oc;
    assign lk_addr_o[g*16 +: 16] = oa;
    assign lk_long_o[g]        = ol;
    assign lk_wdata_o[g*16 +: 16] = wd;

    // burst frames wait in one latch: the network carries at most one burster
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bp <= 1'b0;
        bc <= 8'h00;
        bd <= 32'h0000_0000;
        bt <= 2'h0;
      end else if (lk_burst_i[g]) begin
        bp <= 1'b1;
        bc <= lk_bcmd_i[g*8 +: 8];
        bd <= rdw;
        bt <= lk_rtype_i[g*2 +: 2];
      end else if (st == flm_pkg::S_BSCN && (si >= cnt || hit)) begin
        bp <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st <= flm_pkg::S_IDLE;
        e <= 32'h0000_0000;
        rd <= 32'h0000_0000;
        oa <= 16'h0000;
        wd <= 16'h0000;
        oc <= 8'h00;
        idx <= 7'h00;
        si <= 7'h00;
        pa <= 4'h0;
        rt <= 2'h0;
        gc <= 20'h00000;
        turn <= 1'b0;
        cau <= 1'b0;
        ol <= 1'b0;
        isb <= 1'b0;
      end else begin
        case (st)
          flm_pkg::S_IDLE: begin
            isb <= 1'b0;
            if (bp) begin
              si <= 7'h00;
              st <= flm_pkg::S_BSCN;
            end else if (aon || uon) begin
              st <= flm_pkg::S_PICK;
            end
          end
          flm_pkg::S_PICK: begin
            if (aon && (turn || !uon)) begin
              cau <= 1'b1;
              turn <= 1'b0;
              e <= {8'h00, cfg[g][`FLM_CFG_AB] + {4'h0, pa}, `FLM_AUTO_CMD, pa, 4'h1};
              oc <= `FLM_AUTO_CMD;
              oa <= {12'h000, pa};
              ol <= 1'b0;
              wd <= 16'h0000;
              st <= flm_pkg::S_SEND;
              if (md == flm_pkg::MODE_P) begin
                pa <= 4'h0;
              end else begin
                pa <= (pa == 4'h0 || pa >= lim) ? 4'h1 : pa + 4'h1;
              end
              if (md == flm_pkg::MODE_P && pa != 4'h0) begin
                oa <= 16'h0000;
                e[`FLM_E_SADR] <= 4'h0;
                e[`FLM_E_DBA] <= cfg[g][`FLM_CFG_AB];
              end
              if (md == flm_pkg::MODE_M && (pa == 4'h0 || pa > lim)) begin
                oa <= 16'h0001;
                e[`FLM_E_SADR] <= 4'h1;
                e[`FLM_E_DBA] <= cfg[g][`FLM_CFG_AB] + 8'h01;
                pa <= (lim == 4'h1) ? 4'h1 : 4'h2;
              end
            end else if (uon && idx >= cnt) begin
              idx <= 7'h00;
            end else if (uon) begin
              cau <= 1'b0;
              idx <= (idx + 7'h01 >= cnt) ? 7'h00 : idx + 7'h01;
              e <= ent;
              if (ent[`FLM_E_TYP] != flm_pkg::TYP_BURST) begin
                turn <= 1'b1;
                wd <= ent[`FLM_E_CSEL] ? {8'h00, ent[`FLM_E_CVAL]} : db[ent[`FLM_E_DBA]];
                oa <= {12'h000, ent[`FLM_E_SADR]};
                ol <= 1'b0;
                oc <= ent[`FLM_E_LNG] ? `FLM_ID_CMD : ent[`FLM_E_CNUM];
                st <= ent[`FLM_E_LNG] ? flm_pkg::S_LQRY : flm_pkg::S_SEND;
              end else begin
                // back through idle so a pending burst is not starved
                st <= flm_pkg::S_IDLE;
              end
            end else begin
              st <= flm_pkg::S_IDLE;
            end
          end
          flm_pkg::S_LQRY: begin
            if (dn) begin
              oa <= lrd;
              ol <= 1'b1;
              oc <= e[`FLM_E_CNUM];
              st <= flm_pkg::S_SEND;
            end
          end
          flm_pkg::S_SEND: begin
            if (dn) begin
              rd <= rdw;
              rt <= lk_rtype_i[g*2 +: 2];
              gc <= 20'h00000;
              st <= (e[`FLM_E_TYP] == flm_pkg::TYP_WR) ? flm_pkg::S_GAP : flm_pkg::S_ST0;
            end
          end
          flm_pkg::S_ST0: begin
            if (gnt[g]) begin
              st <= two ? flm_pkg::S_ST1 : flm_pkg::S_GAP;
            end
          end
          flm_pkg::S_ST1: begin
            if (gnt[g]) begin
              st <= flm_pkg::S_GAP;
            end
          end
          flm_pkg::S_GAP: begin
            if (!sec || gc == 20'(GAP_CYC - 1)) begin
              st <= flm_pkg::S_IDLE;
            end else begin
              gc <= gc + 20'h00001;
            end
          end
          flm_pkg::S_BSCN: begin
            if (si >= cnt) begin
              st <= flm_pkg::S_IDLE;
            end else if (hit) begin
              e <= ent;
              rd <= bd;
              rt <= bt;
              isb <= 1'b1;
              st <= flm_pkg::S_ST0;
            end else begin
              si <= si + 7'h01;
            end
          end
          default: begin
            st <= flm_pkg::S_IDLE;
          end
        endcase
      end
    end

    sequence s_lq_done;
      st == flm_pkg::S_LQRY && dn;
    endsequence
    sequence s_rd_done;
      st == flm_pkg::S_SEND && dn && e[`FLM_E_TYP] != flm_pkg::TYP_WR;
    endsequence

    a_ptp_addr: assert property (st == flm_pkg::S_SEND && cau && md == flm_pkg::MODE_P |-> oa == 16'h0000)
      else $error("point-to-point poll left address zero");
    a_md_range: assert property (st == flm_pkg::S_SEND && cau && md == flm_pkg::MODE_M |-> oa >= 16'h0001 && oa <= {12'h000, lim})
      else $error("multi-drop poll address out of range");
    a_none_auto: assert property (md == flm_pkg::MODE_N && st == flm_pkg::S_PICK |=> !(st == flm_pkg::S_SEND && cau))
      else $error("auto-poll issued in mode N");
    a_idx_bound: assert property (idx < `FLM_MAX_CMDS)
      else $error("command index past list end");
    a_long_addr: assert property (s_lq_done |=> st == flm_pkg::S_SEND && ol && oa == $past(lrd))
      else $error("long address not used after query");
    a_gap_hold: assert property (st == flm_pkg::S_GAP && sec && gc < 20'(GAP_CYC - 1) |=> st == flm_pkg::S_GAP)
      else $error("second-master pause cut short");
    a_gap_skip: assert property (st == flm_pkg::S_GAP && !sec |=> st == flm_pkg::S_IDLE)
      else $error("pause taken without second master");
    a_burst_notx: assert property (lk_req_o[g] |-> e[`FLM_E_TYP] != flm_pkg::TYP_BURST)
      else $error("type zero entry transmitted");
    a_dev_int: assert property (st == flm_pkg::S_ST0 && e[`FLM_E_CNUM] >= `FLM_DEV_SPEC |-> w0a == e[`FLM_E_DBA])
      else $error("device-specific data left integer area");
    a_rd_store: assert property (s_rd_done |=> st == flm_pkg::S_ST0 ##1 st != flm_pkg::S_IDLE)
      else $error("response not stored");
  end
endmodule
`default_nettype wire

// >>> flm_loop_model.sv
// flm_loop_model.sv: behavioural frame engine and instruments on all four loops
// assumes requests held until done; answers after DLY+1 cycles, bursts on command
`timescale 1ns/1ps
`default_nettype none
module flm_loop_model #(
  parameter int DLY = 6
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [3:0]   req_i,
  input  wire logic [31:0]  cmd_i,
  input  wire logic [63:0]  addr_i,
  output logic      [3:0]   done_o,
  output logic      [7:0]   rtype_o,
  output logic      [127:0] rdata_o,
  output logic      [3:0]   burst_o,
  output logic      [31:0]  bcmd_o
);
  logic [7:0]  rt = 8'h00;
  logic [31:0] resp [4];
  logic [31:0] bdat [4];
  int          cnt [4];
  initial burst_o = 4'h0;
  initial bcmd_o = 32'h0;
  assign rtype_o = rt;
  // answer carries command and address so every store can be traced
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      done_o[c] <= 1'b0;
      if (rst_i) begin
        cnt[c] <= 0;
      end else if (done_o[c]) begin
        // the edge that takes done is no new request; a next frame may keep req high
        cnt[c] <= 0;
      end else if (req_i[c] && cnt[c] == DLY) begin
        done_o[c] <= 1'b1;
        resp[c] <= {8'h5a, cmd_i[c*8+:8], addr_i[c*16+:16] ^ 16'h1c00};
        cnt[c] <= 0;
      end else if (req_i[c]) begin
        cnt[c] <= cnt[c] + 1;
      end else begin
        resp[c] <= ~resp[c];
      end
    end
  end
  for (genvar c = 0; c < 4; c++) begin : g_rd
    assign rdata_o[c*32+:32] = burst_o[c] ? bdat[c] : resp[c];
  end
  // only one instrument bursts at a time: one call, one channel
  task automatic send_burst(input int c, input logic [7:0] cm, input logic [31:0] d);
    @(posedge clk_i);
    burst_o[c] <= 1'b1;
    bcmd_o[c*8+:8] <= cm;
    bdat[c] <= d;
    @(posedge clk_i);
    burst_o[c] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb_flm_poller.sv
// tb_flm_poller.sv: self-checking bench for the loop poller
// assumes flm_loop_model as far side and a 25 ns clock
`timescale 1ns/1ps
`default_nettype none
module tb_flm_poller;
  logic         clk_i = 0;
  logic         rst_i = 1;
  logic         cyc = 0, stb = 0, we = 0;
  logic [11:0]  adr = 0;
  logic [31:0]  dat = 0, rdat, cmd, bcmd;
  logic         ack, tick, irq;
  logic [3:0]   req, lng, done, bst;
  logic [63:0]  ladr, wdat;
  logic [7:0]   rtyp;
  logic [127:0] rdata;
  int           failures = 0;
  int           n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  flm_poller #(.BAUD_CYC(4), .GAP_CYC(10)) flm_poller_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .lk_req_o(req), .lk_cmd_o(cmd), .lk_addr_o(ladr), .lk_long_o(lng), .lk_wdata_o(wdat),
    .lk_done_i(done), .lk_rtype_i(rtyp), .lk_rdata_i(rdata), .lk_burst_i(bst), .lk_bcmd_i(bcmd),
    .baud_tick_o(tick), .irq_o(irq));
  flm_loop_model flm_loop_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .cmd_i(cmd), .addr_i(ladr),
    .done_o(done), .rtype_o(rtyp), .rdata_o(rdata), .burst_o(bst), .bcmd_o(bcmd));
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    chk(32'h0, 32'h1);
    test_done();
  endtask
  // single classic cycle; waits up to 20 cycles for ack, then reports a timeout
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    q = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(0, a, 0, q);
    chk(q, e);
  endtask
  function automatic logic [11:0] ea(input int c, input int k);
    return 12'h800 + 12'(c * 512 + 4 * k);
  endfunction
  function automatic logic [11:0] ca(input int c);
    return 12'h010 + 12'(4 * c);
  endfunction
  function automatic logic [11:0] da(input int i);
    return 12'h400 + 12'(4 * i);
  endfunction
  // waits for a fresh request: low first, then high
  task automatic nreq(input int c);
    int n;
    n = 0;
    while (req[c] !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    while (req[c] !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) tmo();
  endtask
  // waits for the answer, then one edge: the next frame may follow with no idle cycle
  task automatic ndone(input int c);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done[c] !== 1'b1 && n < 4000);
    if (n >= 4000) tmo();
    @(posedge clk_i);
  endtask
  task automatic wsts(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(0, 12'h000, 0, q);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (n >= 300) tmo();
    wr(12'h000, 32'h1 << b);
  endtask
  task automatic off(input int c);
    wr(ca(c), 0);
    repeat (30) @(posedge clk_i);
  endtask
  task automatic t_reset();
    int k;
    k = 0;
    rd(12'h000, 0);
    rd(12'h008, 0);
    rd(ca(3), 0);
    wr(12'h3f0, 32'hffff_ffff);
    rd(12'h3f0, 0);
    repeat (40) begin
      @(posedge clk_i);
      if (tick === 1'b1) k++;
    end
    chk(k, 10);
  endtask
  task automatic t_user();
    wr(ea(1, 0), {8'h00, 8'h20, 8'h10, 4'h3, 4'h1});
    wr(ca(1), {8'h00, 8'h60, 8'h01, 8'h00});
    nreq(1);
    chk(cmd[15:8], 8'h10);
    chk(ladr[31:16], 16'h0003);
    nreq(1);
    chk(cmd[15:8], 8'h10);
    wsts(1);
    wsts(1);
    rd(da(8'h20), 32'h1c03);
    flm_loop_model_i.rt[3:2] <= 2'd1;
    wsts(1);
    wsts(1);
    rd(da(8'h60), 32'h5a10);
    rd(da(8'h61), 32'h1c03);
    off(1);
    wr(ea(1, 0), {8'h00, 8'h24, 8'h90, 4'h3, 4'h1});
    wr(ca(1), {8'h00, 8'h60, 8'h01, 8'h00});
    wsts(1);
    wsts(1);
    rd(da(8'h24), 32'h5a90);
    rd(da(8'h25), 32'h1c03);
    off(1);
    wr(12'h004, 32'h2);
    @(posedge clk_i);
    chk(irq, 1);
    wr(12'h004, 32'h0);
    @(posedge clk_i);
    chk(irq, 0);
    wr(12'h004, 32'h2);
    wr(12'h000, 32'h2);
    @(posedge clk_i);
    chk(irq, 0);
  endtask
  task automatic t_gap();
    int g [2];
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(ca(1), {16'h0060, 8'h01, 5'h0, 1'(s), 2'h0});
      repeat (2) begin
        n = 0;
        while (done[1] !== 1'b1 && n < 500) begin
          @(posedge clk_i);
          n++;
        end
        @(posedge clk_i);
        g[s] = 0;
        while (req[1] !== 1'b1 && n < 500) begin
          @(posedge clk_i);
          g[s]++;
          n++;
        end
        if (n >= 500) tmo();
      end
    end
    chk(g[1] - g[0], 9);
    off(1);
  endtask
  task automatic t_const();
    wr(da(8'h30), 32'h1234);
    wr(ea(2, 0), {8'h7e, 8'h00, 8'h21, 4'h5, 4'he});
    wr(ea(2, 1), {8'h00, 8'h30, 8'h22, 4'h5, 4'h2});
    wr(ca(2), {16'h0, 8'h02, 8'h00});
    nreq(2);
    chk({cmd[23:16], lng[2], ladr[47:32]}, {8'h00, 1'b0, 16'h0005});
    ndone(2);
    chk({req[2], cmd[23:16], lng[2], ladr[47:32]}, {1'b1, 8'h21, 1'b1, 16'h1c05});
    chk(wdat[47:32], 16'h007e);
    nreq(2);
    chk({cmd[23:16], lng[2], wdat[47:32]}, {8'h22, 1'b0, 16'h1234});
    off(2);
  endtask
  task automatic t_point();
    logic [7:0] p;
    wr(ea(3, 0), {8'h00, 8'h38, 8'h11, 4'h2, 4'h1});
    wr(ca(3), {8'h40, 16'h0001, 8'h02});
    nreq(3);
    p = cmd[31:24];
    for (int i = 0; i < 4; i++) begin
      nreq(3);
      chk(cmd[31:24] ^ p, 8'h12);
      if (cmd[31:24] === 8'h03) chk(ladr[51:48], 4'h0);
      p = cmd[31:24];
    end
    wsts(3);
    wsts(3);
    rd(da(8'h40), 32'h1c00);
    off(3);
  endtask
  task automatic t_multi();
    logic [3:0] a;
    logic [3:0] hi;
    logic       z;
    hi = 0;
    z = 0;
    wr(ca(0), 32'h1);
    for (int i = 0; i < 16; i++) begin
      nreq(0);
      chk(cmd[7:0], 8'h03);
      if (ladr[3:0] > hi) hi = ladr[3:0];
      if (ladr[3:0] === 4'h0) z = 1;
    end
    chk({z, hi}, 5'h0f);
    off(0);
    wr(ca(0), 32'h21);
    nreq(0);
    a = ladr[3:0];
    for (int i = 0; i < 3; i++) begin
      nreq(0);
      chk(ladr[3:0] ^ a, 4'h3);
      a = ladr[3:0];
    end
    off(0);
  endtask
  task automatic t_burst();
    int k;
    k = 0;
    wr(ea(0, 0), {8'h00, 8'h50, 8'h30, 8'h00});
    wr(ca(0), 32'h100);
    repeat (60) begin
      @(posedge clk_i);
      if (req[0] !== 1'b0) k++;
    end
    chk(k, 0);
    flm_loop_model_i.send_burst(0, 8'h30, 32'h0000_beef);
    wsts(4);
    rd(da(8'h50), 32'hbeef);
    off(0);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_user();
    t_gap();
    t_const();
    t_point();
    t_multi();
    t_burst();
    test_done();
  end
endmodule
`default_nettype wire
